// file: hw/cplb_logic_block.sv
// One logic block: term array, term allocator, sixteen macrocells and a register bus slave.
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Overview of operation
// - Array takes 36 routing inputs in both polarities, yields 86 product terms.
// - Each macrocell sums a configurable count of terms, zero to sixteen.
// - One product term may feed several macrocell sums at once.
// - Block holds sixteen macrocells fed by the array through the allocator.
// - One pin per macrocell pair; the other macrocell of the pair is buried.
// - Pin macrocell register can be bypassed so the sum passes on after one core clock, without waiting for a global clock edge.
// - Pin macrocell can invert the sum before register or bypass.
// - Macrocell register clock is chosen from two global clocks.
// - Pin macrocell feeds back to routing separately from its pin.
// - Buried storage is combinational, D, T or latch; same clock choice.
// - Buried macrocell can register its neighbour's pin, D-type or latch.
// - Every buried macrocell output goes straight to the routing matrix.
// - All array inputs arrive only through the global routing matrix.
// - Each pin and clock input has a keeper holding its last level.
// ----------------------------------------------------------------
module cplb_logic_block #(
  parameter int unsigned N_IN   = 36,
  parameter int unsigned N_TERM = 86,
  parameter int unsigned N_MC   = 16,
  parameter int unsigned N_SLOT = 16
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [11:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic [N_IN-1:0]       global_routing_matrix_i,
  input  wire logic [1:0]            gclk_i,
  input  wire logic [N_MC/2-1:0]     pin_i,
  output logic      [N_MC/2-1:0]     pin_o,
  output logic      [N_MC/2-1:0]     pin_oe_o,
  output logic      [N_MC/2-1:0]     pin_hold_o,
  output logic      [1:0]            gclk_hold_o,
  output logic      [N_MC-1:0]       global_routing_matrix_o
);
  localparam int unsigned N_PIN = N_MC / 2;
  localparam int unsigned ROW_W = 2 * N_IN;
  localparam int unsigned N_SYN = N_PIN + 2;

  // ----------------------------------------------------------------
  // Decoding shared by the write and read paths
  // ----------------------------------------------------------------
  function automatic cplb_pkg::cplb_region_t region(input logic [11:0] a);
    if (a[11]) begin
      region = cplb_pkg::REG_TERM;
    end else if (a[10]) begin
      region = cplb_pkg::REG_SLOT;
    end else if (a[8]) begin
      region = cplb_pkg::REG_MCFG;
    end else begin
      region = cplb_pkg::REG_STAT;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction

  // ----------------------------------------------------------------
  // Configuration store
  // ----------------------------------------------------------------
  logic [ROW_W-1:0]  term_q [N_TERM];
  logic [ROW_W-1:0]  term_d [N_TERM];
  logic [7:0]        slot_q [N_MC][N_SLOT];
  logic [7:0]        slot_d [N_MC][N_SLOT];
  localparam int unsigned MCFG_W_L = cplb_pkg::MCFG_W;
  logic [MCFG_W_L-1:0] mcfg_q [N_MC];
  logic [MCFG_W_L-1:0] mcfg_d [N_MC];
  logic [N_SYN-1:0]  s1_q, s2_q, s3_q, lvl_q, lvl_d, rise_q, rise_d;
  logic [N_MC-1:0]   mc_q, mc_d;
  logic              ack_q, ack_d;
  logic [31:0]       dat_q, dat_d;
  logic              req;
  logic [95:0]       row_pad;
  logic [6:0]        t_idx;
  logic [3:0]        mc_idx;

  assign req    = wb_cyc_i & wb_stb_i & ~ack_q;
  assign t_idx  = wb_adr_i[10:4];
  assign mc_idx = wb_adr_i[9:6];

  // Configuration is written by the bus on write requests to the term, slot and macrocell regions, while the macrocells keep running.
  always_comb begin
    term_d  = term_q;
    slot_d  = slot_q;
    mcfg_d  = mcfg_q;
    ack_d   = req;
    dat_d   = 32'h0000_0000;
    row_pad = 96'h0;
    if (req) begin
      case (region(wb_adr_i))
        cplb_pkg::REG_TERM: begin
          if (t_idx < 7'(N_TERM)) begin
            row_pad = 96'(term_q[t_idx]);
            if (wb_we_i && wb_adr_i[3:2] != 2'h3) begin
              row_pad[wb_adr_i[3:2]*32 +: 32] = merge(row_pad[wb_adr_i[3:2]*32 +: 32], wb_dat_i, wb_sel_i);
              term_d[t_idx] = row_pad[ROW_W-1:0];
            end
            dat_d = (wb_adr_i[3:2] == 2'h3) ? 32'h0000_0000 : row_pad[wb_adr_i[3:2]*32 +: 32];
          end
        end
        cplb_pkg::REG_SLOT: begin
          if (wb_we_i && wb_sel_i[0]) begin
            slot_d[mc_idx][wb_adr_i[5:2]] = wb_dat_i[7:0];
          end
          dat_d = {24'h000000, slot_q[mc_idx][wb_adr_i[5:2]]};
        end
        cplb_pkg::REG_MCFG: begin
          if (wb_we_i && wb_sel_i[0]) begin
            mcfg_d[wb_adr_i[5:2]] = wb_dat_i[MCFG_W_L-1:0];
          end
          dat_d = 32'(mcfg_q[wb_adr_i[5:2]]);
        end
        default: begin
          if (wb_adr_i == cplb_pkg::STAT_OFS) begin
            dat_d = 32'({lvl_q[N_PIN-1:0], mc_q});
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int t = 0; t < N_TERM; t++) begin
        term_q[t] <= '0;
      end
      for (int m = 0; m < N_MC; m++) begin
        mcfg_q[m] <= cplb_pkg::MCFG_RST;
        for (int s = 0; s < N_SLOT; s++) begin
          slot_q[m][s] <= cplb_pkg::SLOT_RST;
        end
      end
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      term_q <= term_d;
      slot_q <= slot_d;
      mcfg_q <= mcfg_d;
      ack_q  <= ack_d;
      dat_q  <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------------------------------
  // Pin and global clock synchronisers with keepers
  // ----------------------------------------------------------------
  logic [N_PIN-1:0] hold_q, hold_d;
  logic [1:0]       ghold_q;

  // A change only counts once the second and third stages agree.
  always_comb begin
    for (int i = 0; i < N_SYN; i++) begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : lvl_q[i];
    end
    rise_d = lvl_d & ~lvl_q;
    for (int k = 0; k < N_PIN; k++) begin
      hold_d[k] = pin_oe_o[k] ? mc_q[2*k] : lvl_q[k];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      lvl_q   <= '0;
      rise_q  <= '0;
      hold_q  <= '0;
      ghold_q <= 2'h0;
    end else begin
      s1_q    <= {gclk_i, pin_i};
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      lvl_q   <= lvl_d;
      rise_q  <= rise_d;
      hold_q  <= hold_d;
      ghold_q <= lvl_q[N_SYN-1 -: 2];
    end
  end

  assign pin_hold_o  = hold_q;
  assign gclk_hold_o = ghold_q;

  // ----------------------------------------------------------------
  // Product term array and allocator
  // ----------------------------------------------------------------
  logic [ROW_W-1:0]  lits;
  logic [N_TERM-1:0] pterm;
  logic [N_MC-1:0]   sum, sum_pol;

  always_comb begin
    lits = {~global_routing_matrix_i, global_routing_matrix_i};
    for (int t = 0; t < N_TERM; t++) begin
      pterm[t] = &(~term_q[t] | lits);
    end
    for (int m = 0; m < N_MC; m++) begin
      sum[m] = 1'b0;
      for (int s = 0; s < N_SLOT; s++) begin
        // Slots of different macrocells may name the same term.
        if (slot_q[m][s][cplb_pkg::SLOT_VLD] && slot_q[m][s][6:0] < 7'(N_TERM)) begin
          sum[m] = sum[m] | pterm[slot_q[m][s][6:0]];
        end
      end
      sum_pol[m] = sum[m] ^ mcfg_q[m][cplb_pkg::MC_INV];
    end
  end

  // ----------------------------------------------------------------
  // Macrocells: even ones own a pin, odd ones are buried
  // ----------------------------------------------------------------
  // Combinational mode still passes through this flop, costing one core clock of latency.
  always_comb begin
    for (int m = 0; m < N_MC; m++) begin
      logic             cs;
      logic             din;
      logic [1:0]       md;
      cs  = mcfg_q[m][cplb_pkg::MC_CSEL];
      din = sum_pol[m];
      md  = mcfg_q[m][cplb_pkg::MC_MODE +: 2];
      if (m % 2 == 0) begin
        md = (md == cplb_pkg::MODE_COMB) ? cplb_pkg::MODE_COMB : cplb_pkg::MODE_D;
      end else if (mcfg_q[m][cplb_pkg::MC_INREG]) begin
        din = lvl_q[m/2];
        md  = (md == cplb_pkg::MODE_LATCH) ? cplb_pkg::MODE_LATCH : cplb_pkg::MODE_D;
      end
      mc_d[m] = mc_q[m];
      case (md)
        cplb_pkg::MODE_COMB:  mc_d[m] = din;
        cplb_pkg::MODE_D: begin
          if (rise_q[N_PIN+cs]) begin
            mc_d[m] = din;
          end
        end
        cplb_pkg::MODE_T: begin
          if (rise_q[N_PIN+cs] && din) begin
            mc_d[m] = ~mc_q[m];
          end
        end
        default: begin
          if (lvl_q[N_PIN+cs]) begin
            mc_d[m] = din;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mc_q <= '0;
    end else begin
      mc_q <= mc_d;
    end
  end

  // Feedback is the macrocell flop itself, so it stays valid while the pin is an input.
  assign global_routing_matrix_o = mc_q;

  generate
    for (genvar k = 0; k < N_PIN; k++) begin : g_pin
      assign pin_o[k]    = mc_q[2*k];
      assign pin_oe_o[k] = mcfg_q[2*k][cplb_pkg::MC_OE];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  AST_ACK_ONE: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus request not answered in exactly one cycle.");
  AST_COMB_PASS: assert property (mcfg_q[0][3:2] == 2'h0 |=> mc_q[0] == $past(sum_pol[0]))
    else $error("Bypassed pin macrocell did not follow its sum.");
  AST_POLARITY: assert property (sum_pol[2] == (sum[2] ^ mcfg_q[2][0]))
    else $error("Sum polarity not applied.");
  AST_D_HOLD: assert property (mcfg_q[0][3:2] == 2'h1 && !rise_q[N_PIN+mcfg_q[0][1]] |=> $stable(mc_q[0]))
    else $error("D register changed without a clock edge.");
  AST_T_TOGGLE: assert property (mcfg_q[1][4:2] == 3'h2 && rise_q[N_PIN+mcfg_q[1][1]] && sum_pol[1]
                                 |=> mc_q[1] != $past(mc_q[1]))
    else $error("T register failed to toggle.");
  AST_LATCH: assert property (mcfg_q[5][4:2] == 3'h3 && lvl_q[N_PIN+mcfg_q[5][1]]
                              |=> mc_q[5] == $past(sum_pol[5]))
    else $error("Latch not transparent while clock high.");
  AST_INREG: assert property (mcfg_q[3][4:2] == 3'h5 && rise_q[N_PIN+mcfg_q[3][1]]
                              |=> mc_q[3] == $past(lvl_q[1]))
    else $error("Input register missed the neighbour pin.");
  AST_FEEDBACK: assert property (global_routing_matrix_o[0] == pin_o[0]
                                 && global_routing_matrix_o[1] == mc_q[1])
    else $error("Feedback differs from macrocell output.");
  AST_KEEPER: assert property (!pin_oe_o[1] ##1 !pin_oe_o[1] |-> pin_hold_o[1] == $past(lvl_q[1]))
    else $error("Keeper lost the last pin level.");
endmodule

// file: hw/cplb_pkg.sv
// Shared constants of the logic block: register map, field positions and reset values.
package cplb_pkg;
  // ----------------------------------------------------------------
  // Register map, byte addresses on the register bus
  // ----------------------------------------------------------------
  localparam int unsigned ADR_W     = 12;
  localparam logic [11:0] STAT_OFS  = 12'h000;
  localparam logic [11:0] MCFG_BASE = 12'h100;
  localparam logic [11:0] SLOT_BASE = 12'h400;
  localparam logic [11:0] TERM_BASE = 12'h800;
  // ----------------------------------------------------------------
  // Macrocell configuration fields
  // ----------------------------------------------------------------
  localparam int unsigned MC_INV   = 0;
  localparam int unsigned MC_CSEL  = 1;
  localparam int unsigned MC_MODE  = 2;
  localparam int unsigned MC_INREG = 4;
  localparam int unsigned MC_OE    = 5;
  localparam int unsigned MCFG_W   = 6;
  localparam logic [5:0]  MCFG_RST = 6'h00;
  // ----------------------------------------------------------------
  // Term slot fields: index in the low bits, valid on top
  // ----------------------------------------------------------------
  localparam int unsigned SLOT_IDX_W = 7;
  localparam int unsigned SLOT_VLD   = 7;
  localparam logic [7:0]  SLOT_RST   = 8'h00;
  typedef enum logic [1:0] {
    MODE_COMB  = 2'h0,
    MODE_D     = 2'h1,
    MODE_T     = 2'h2,
    MODE_LATCH = 2'h3
  } cplb_mode_t;
  typedef enum logic [1:0] {
    REG_STAT = 2'h0,
    REG_MCFG = 2'h1,
    REG_SLOT = 2'h2,
    REG_TERM = 2'h3
  } cplb_region_t;
endpackage

// file: tb/cplb_far_end.sv
// Far-side model of the pins: outside drivers meeting the block's pin drivers and keepers.
`timescale 1ns/10ps
module cplb_far_end (
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] pin_oe_i,
  input  wire logic [7:0] pin_hold_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  output logic      [7:0] pin_lvl_o
);
  // The block wins while it drives, then an outside driver, else the weak keeper level.
  // Nothing ever drives against the block, so no contention state is modelled.
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      pin_lvl_o[k] = pin_oe_i[k] ? pin_o_i[k] : (ext_en_i[k] ? ext_val_i[k] : pin_hold_i[k]);
    end
  end
endmodule

// file: tb/test_cplb_logic_block.sv
// Self-checking bench for the logic block: bus setup, sums, storage modes and pins.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); \
  end \
end
module test_cplb_logic_block;
  logic        clk, rst, cyc, stb, we, ack;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] dat, rdat, q;
  logic [35:0] grm_in;
  logic [1:0]  gclk, gclk_hold;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_hold, ext_en, ext_val;
  logic [15:0] grm_out;
  int          n_fail, checks_done;

  cplb_logic_block DUT (
    .core_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .global_routing_matrix_i(grm_in), .gclk_i(gclk), .pin_i(pin_in), .pin_o(pin_out),
    .pin_oe_o(pin_oe), .pin_hold_o(pin_hold), .gclk_hold_o(gclk_hold),
    .global_routing_matrix_o(grm_out));

  cplb_far_end far (
    .pin_o_i(pin_out), .pin_oe_i(pin_oe), .pin_hold_i(pin_hold),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_lvl_o(pin_in));

  // ----------------------------------------------------------------
  // Bus and clock helpers
  // ----------------------------------------------------------------
  function automatic logic [11:0] mcfg(input int m);
    return cplb_pkg::MCFG_BASE + 12'(4 * m);
  endfunction
  function automatic logic [11:0] slot(input int m, input int s);
    return cplb_pkg::SLOT_BASE + 12'(m * 64 + s * 4);
  endfunction
  function automatic logic [11:0] term(input int t, input int w);
    return cplb_pkg::TERM_BASE + 12'(t * 16 + w * 4);
  endfunction

  // Called just after a rising edge; the request stands until ack is sampled high.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = rdat;
    if (n >= 16) begin
      n_fail++;
      $display("ERROR bus ack expected 1 seen 0");
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask

  // Clock pins pass a three-flop synchroniser, so each level is held well past it.
  task automatic gc(input int c, input logic v);
    gclk[c] <= v;
    repeat (8) @(posedge clk);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    bus(1'b0, cplb_pkg::STAT_OFS, 32'h0); `CHK("status", 32'h0, q)
    bus(1'b0, mcfg(0), 32'h0); `CHK("mcfg0", 32'h0, q)
    bus(1'b0, slot(0, 0), 32'h0); `CHK("slot0", 32'h0, q)
    bus(1'b0, 12'h0f0, 32'h0); `CHK("unmapped", 32'h0, q)
    `CHK("pin_oe", 8'h00, pin_oe)
    `CHK("routing out", 16'h0000, grm_out)
    $display("test reset done");
  endtask

  task automatic t_sum;
    logic [1:0] v;
    logic       e;
    bus(1'b1, term(0, 0), 32'h1);
    bus(1'b1, term(1, 1), 32'h20);
    bus(1'b1, slot(0, 0), 32'h80);
    bus(1'b1, slot(0, 1), 32'h81);
    bus(1'b1, slot(2, 0), 32'h80);
    for (int inv = 0; inv < 2; inv++) begin
      bus(1'b1, mcfg(0), 32'h20 | 32'(inv));
      bus(1'b0, mcfg(0), 32'h0); `CHK("mcfg0", 32'h20 | 32'(inv), q)
      for (int k = 0; k < 4; k++) begin
        v = 2'(k);
        e = (v[0] | ~v[1]) ^ inv[0];
        grm_in[1:0] <= v;
        repeat (3) @(posedge clk);
        `CHK("sum", e, grm_out[0])
        `CHK("pin", e, pin_out[0])
        `CHK("shared", v[0], grm_out[2])
        `CHK("no terms", 1'b0, grm_out[4])
      end
    end
    `CHK("oe", 1'b1, pin_oe[0])
    $display("test sums done");
  endtask

  task automatic t_dreg;
    bus(1'b1, mcfg(0), 32'h26);
    grm_in[1:0] <= 2'b11;
    gc(0, 1'b1); gc(0, 1'b0);
    `CHK("other clock", 1'b0, pin_out[0])
    gc(1, 1'b1); gc(1, 1'b0);
    `CHK("chosen clock", 1'b1, pin_out[0])
    `CHK("feedback", 1'b1, grm_out[0])
    grm_in[1:0] <= 2'b10;
    gc(1, 1'b1); gc(1, 1'b0);
    `CHK("d low", 1'b0, pin_out[0])
    $display("test d register done");
  endtask

  task automatic t_buried;
    bus(1'b1, mcfg(1), 32'h08);
    bus(1'b1, slot(1, 0), 32'h82);
    for (int k = 1; k <= 2; k++) begin
      gc(0, 1'b1); gc(0, 1'b0);
      `CHK("toggle", 1'(k), grm_out[1])
    end
    bus(1'b1, mcfg(5), 32'h0c);
    bus(1'b1, slot(5, 0), 32'h80);
    gc(0, 1'b1);
    `CHK("clock keeper", 2'b01, gclk_hold)
    grm_in[0] <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("latch open", 1'b1, grm_out[5])
    gc(0, 1'b0);
    grm_in[0] <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("latch shut", 1'b1, grm_out[5])
    $display("test buried done");
  endtask

  task automatic t_inreg;
    bus(1'b1, mcfg(3), 32'h14);
    ext_en[1] <= 1'b1;
    ext_val[1] <= 1'b1;
    repeat (6) @(posedge clk);
    gc(0, 1'b1); gc(0, 1'b0);
    `CHK("input reg", 1'b1, grm_out[3])
    ext_en[1] <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("keeper", 1'b1, pin_hold[1])
    bus(1'b0, cplb_pkg::STAT_OFS, 32'h0);
    `CHK("stat pin", 1'b1, q[17])
    `CHK("stat mc", 1'b1, q[3])
    $display("test input register done");
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end

  initial begin
    n_fail = 0;
    checks_done = 0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h000;
    sel = 4'h0;
    dat = 32'h0;
    grm_in = 36'h0;
    gclk = 2'h0;
    ext_en = 8'h00;
    ext_val = 8'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_sum();
    t_dreg();
    t_buried();
    t_inreg();
    results();
  end
endmodule
